// *** logic/regulator_regs_pkg.sv ***
// Package: offsets, reset values, field positions and delay timing for the regulator bank
package regulator_regs_pkg;
	localparam logic [7:0] converter_b_voltage_code_off  = 8'h07;
	localparam logic [7:0] linear_reg_a_control_off      = 8'h08;
	localparam logic [7:0] linear_reg_b_control_off      = 8'h09;
	localparam logic [7:0] linear_reg_a_voltage_code_off = 8'h0A;
	localparam logic [7:0] linear_reg_b_voltage_code_off = 8'h0B;
	localparam logic [7:0] linear_reg_a_delay_off        = 8'h0E;
	localparam logic [7:0] linear_reg_b_delay_off        = 8'h0F;

	localparam logic [7:0] converter_b_voltage_rst = 8'h93;
	localparam logic [4:0] linear_voltage_rst      = 5'h0A;
	localparam logic [7:0] linear_a_delay_rst      = 8'h31;
	localparam logic [7:0] linear_b_delay_rst      = 8'h26;

	localparam int enable_bit_pos    = 0;
	localparam int pin_gating_pos    = 1;
	localparam int discharge_en_pos  = 2;
	localparam logic enable_bit_rst  = 1'b1;
	localparam logic pin_gating_rst  = 1'b1;
	localparam logic discharge_rst   = 1'b1;

	localparam logic [7:0] conv_code_fine_lo   = 8'h14;
	localparam logic [7:0] conv_code_mid_lo    = 8'h18;
	localparam logic [7:0] conv_code_coarse_lo = 8'h9E;
	localparam logic [15:0] conv_fine_base_mv  = 16'h02BC;
	localparam logic [15:0] conv_mid_base_mv   = 16'h02DF;
	localparam logic [15:0] conv_coarse_base_mv = 16'h058C;
	localparam logic [15:0] conv_fine_step_mv  = 16'h000A;
	localparam logic [15:0] conv_mid_step_mv   = 16'h0005;
	localparam logic [15:0] conv_coarse_step_mv = 16'h0014;
	localparam logic [4:0] linear_code_max     = 5'h19;
	localparam logic [15:0] linear_base_mv     = 16'h0320;
	localparam logic [15:0] linear_step_mv     = 16'h0064;

	localparam int clk_rate_hz     = 10_000_000;
	localparam int delay_step_us   = 500;
	localparam int delay_step_cyc  = (delay_step_us * (clk_rate_hz / 1_000_000));

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic        enabled;
		logic        discharge;
		logic [15:0] target_mv;
	} linear_status_t;
endpackage

// *** logic/linear_sequencer.sv ***
// One linear regulator: enable qualification and pin-edge delay sequencing
`timescale 1ns/1ps
module linear_sequencer
	import regulator_regs_pkg::*;
#(
	parameter int STEP_CYC = delay_step_cyc
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       sys_rst,
	// Register fields
	input  wire logic       enable_bit,
	input  wire logic       pin_gating,
	input  wire logic       discharge_enable,
	input  wire logic [3:0] startup_delay,
	input  wire logic [3:0] shutdown_delay,
	// Synchronised enable pin and its edges
	input  wire logic       pin_level,
	input  wire logic       pin_rise,
	input  wire logic       pin_fall,
	// Regulator drive
	output logic            reg_on,
	output logic            discharge_on
);
	typedef enum logic [3:0] {
		st_off   = 4'b0001,
		st_start = 4'b0010,
		st_on    = 4'b0100,
		st_stop  = 4'b1000
	} seq_state_t;

	seq_state_t  state_q, state_d;
	logic [19:0] cnt_q, cnt_d;
	logic        on_q, on_d;
	logic        dis_q, dis_d;
	logic        want_on;

	function automatic logic [19:0] delay_cycles(input logic [3:0] steps);
		delay_cycles = 20'(steps) * 20'(STEP_CYC);
	endfunction

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		// both bit and pin when gated
		want_on = pin_gating ? (enable_bit && pin_level) : enable_bit;
		case (state_q)
			st_off: begin
				if (want_on && pin_gating && pin_rise && startup_delay != 4'h0) begin
					state_d = st_start;
					cnt_d   = delay_cycles(startup_delay);
				end else if (want_on) begin
					state_d = st_on;
				end
			end
			st_start: begin
				if (!want_on) begin
					state_d = st_off;
				end else if (cnt_q <= 20'h00001) begin
					state_d = st_on;
				end else begin
					cnt_d = cnt_q - 20'h00001;
				end
			end
			st_on: begin
				if (pin_gating && enable_bit && pin_fall && shutdown_delay != 4'h0) begin
					state_d = st_stop;
					cnt_d   = delay_cycles(shutdown_delay);
				end else if (!want_on) begin
					state_d = st_off;
				end
			end
			st_stop: begin
				if (!enable_bit || !pin_gating || cnt_q <= 20'h00001) begin
					state_d = st_off;
				end else if (pin_level) begin
					state_d = st_on;
				end else begin
					cnt_d = cnt_q - 20'h00001;
				end
			end
			default: begin
				state_d = st_off;
			end
		endcase
		on_d  = (state_d == st_on) || (state_d == st_stop);
		dis_d = !on_d && discharge_enable;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= st_off;
			cnt_q   <= 20'h00000;
			on_q    <= 1'b0;
			dis_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			on_q    <= on_d;
			dis_q   <= dis_d;
		end
	end

	assign reg_on       = on_q;
	assign discharge_on = dis_q;
endmodule

// *** logic/regulator_enable_voltage_regs.sv ***
// Register bank for converter B voltage and the two linear regulators
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
//
// Operation
// - Converter B voltage register is 8-bit read/write, resets to 0x93.
// - Codes 0x14-0x17 give 0.70-0.73 V in 10 mV steps.
// - Codes 0x18-0x9D give 0.735-1.4 V in 5 mV steps.
// - Codes 0x9E-0xFF give 1.42-3.36 V in 20 mV steps.
// - Regulator A discharge resistor applies while disabled if bit 2; resets 1.
// - Regulator A bit 1 adds pin gating to enable bit; resets 1.
// - Regulator A bit 0 enables the regulator; resets 1.
// - Regulator B discharge resistor applies while disabled if bit 2; resets 1.
// - Regulator B bit 1 adds pin gating to enable bit; resets 1.
// - Regulator B bit 0 enables the regulator; resets 1.
// - Regulator A voltage 0x00 is 0.8 V, 100 mV per code; resets 0xA.
// - Regulator B voltage 0x00 is 0.8 V, 100 mV per code; resets 0xA.
// - Startup delay counts from pin rise, shutdown delay from pin fall.
module regulator_enable_voltage_regs
	import regulator_regs_pkg::*;
#(
	parameter int STEP_CYC = delay_step_cyc
) (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           sys_rst,
	// Register port
	input  wire logic [7:0]     reg_addr,
	input  wire logic [7:0]     reg_wdata,
	input  wire logic           reg_wr,
	input  wire logic           reg_rd,
	output logic      [7:0]     reg_rdata,
	// External enable pin
	input  wire logic           enable_pin,
	// Converter B target
	output logic      [7:0]     converter_b_code,
	output logic      [15:0]    converter_b_target_mv,
	output logic                converter_b_code_valid,
	// Linear regulators
	output linear_status_t      linear_a_status,
	output linear_status_t      linear_b_status
);
	reg_req_t    req;
	logic [7:0]  conv_q, conv_d;
	logic [2:0]  ctrl_a_q, ctrl_a_d;
	logic [2:0]  ctrl_b_q, ctrl_b_d;
	logic [4:0]  volt_a_q, volt_a_d;
	logic [4:0]  volt_b_q, volt_b_d;
	logic [7:0]  dly_a_q, dly_a_d;
	logic [7:0]  dly_b_q, dly_b_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        pin_meta_q, pin_sync_q, pin_prev_q;
	logic        pin_meta_d, pin_sync_d, pin_prev_d;
	logic        pin_rise, pin_fall;
	logic        on_a, on_b, dis_a, dis_b;
	logic [15:0] conv_mv_q, conv_mv_d;
	logic        conv_ok_q, conv_ok_d;
	logic [15:0] lin_a_mv_q, lin_a_mv_d;
	logic [15:0] lin_b_mv_q, lin_b_mv_d;

	function automatic logic [15:0] converter_mv(input logic [7:0] code);
		converter_mv = 16'h0000;
		if (code >= conv_code_coarse_lo) begin
			converter_mv = conv_coarse_base_mv
				+ 16'(code - conv_code_coarse_lo) * conv_coarse_step_mv;
		end else if (code >= conv_code_mid_lo) begin
			converter_mv = conv_mid_base_mv + 16'(code - conv_code_mid_lo) * conv_mid_step_mv;
		end else if (code >= conv_code_fine_lo) begin
			converter_mv = conv_fine_base_mv
				+ 16'(code - conv_code_fine_lo) * conv_fine_step_mv;
		end
	endfunction

	function automatic logic [15:0] linear_mv(input logic [4:0] code);
		linear_mv = linear_base_mv + 16'(code) * linear_step_mv;
	endfunction

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	always_comb begin
		conv_d   = conv_q;
		ctrl_a_d = ctrl_a_q;
		ctrl_b_d = ctrl_b_q;
		volt_a_d = volt_a_q;
		volt_b_d = volt_b_q;
		dly_a_d  = dly_a_q;
		dly_b_d  = dly_b_q;
		rdata_d  = 8'h00;
		// Reserved codes are stored as written; converter_b_code_valid flags converter ones, linear targets clamp them
		if (req.wr) begin
			case (req.addr)
				converter_b_voltage_code_off: begin
					conv_d = req.wdata;
				end
				linear_reg_a_control_off: begin
					ctrl_a_d = req.wdata[2:0];
				end
				linear_reg_b_control_off: begin
					ctrl_b_d = req.wdata[2:0];
				end
				linear_reg_a_voltage_code_off: begin
					volt_a_d = req.wdata[4:0];
				end
				linear_reg_b_voltage_code_off: begin
					volt_b_d = req.wdata[4:0];
				end
				linear_reg_a_delay_off: begin
					dly_a_d = req.wdata;
				end
				linear_reg_b_delay_off: begin
					dly_b_d = req.wdata;
				end
				default: begin
				end
			endcase
		end
		// Unmapped reads return zero
		if (req.rd) begin
			case (req.addr)
				converter_b_voltage_code_off:  rdata_d = conv_q;
				linear_reg_a_control_off:      rdata_d = {5'h00, ctrl_a_q};
				linear_reg_b_control_off:      rdata_d = {5'h00, ctrl_b_q};
				linear_reg_a_voltage_code_off: rdata_d = {3'h0, volt_a_q};
				linear_reg_b_voltage_code_off: rdata_d = {3'h0, volt_b_q};
				linear_reg_a_delay_off:        rdata_d = dly_a_q;
				linear_reg_b_delay_off:        rdata_d = dly_b_q;
				default:                       rdata_d = 8'h00;
			endcase
		end
		conv_mv_d  = converter_mv(conv_q);
		conv_ok_d  = conv_q >= conv_code_fine_lo;
		// reserved high codes clamp to the top step
		lin_a_mv_d = linear_mv((volt_a_q > linear_code_max) ? linear_code_max : volt_a_q);
		lin_b_mv_d = linear_mv((volt_b_q > linear_code_max) ? linear_code_max : volt_b_q);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			conv_q     <= converter_b_voltage_rst;
			ctrl_a_q   <= {discharge_rst, pin_gating_rst, enable_bit_rst};
			ctrl_b_q   <= {discharge_rst, pin_gating_rst, enable_bit_rst};
			volt_a_q   <= linear_voltage_rst;
			volt_b_q   <= linear_voltage_rst;
			dly_a_q    <= linear_a_delay_rst;
			dly_b_q    <= linear_b_delay_rst;
			rdata_q    <= 8'h00;
			conv_mv_q  <= 16'h0000;
			conv_ok_q  <= 1'b0;
			lin_a_mv_q <= 16'h0000;
			lin_b_mv_q <= 16'h0000;
		end else begin
			conv_q     <= conv_d;
			ctrl_a_q   <= ctrl_a_d;
			ctrl_b_q   <= ctrl_b_d;
			volt_a_q   <= volt_a_d;
			volt_b_q   <= volt_b_d;
			dly_a_q    <= dly_a_d;
			dly_b_q    <= dly_b_d;
			rdata_q    <= rdata_d;
			conv_mv_q  <= conv_mv_d;
			conv_ok_q  <= conv_ok_d;
			lin_a_mv_q <= lin_a_mv_d;
			lin_b_mv_q <= lin_b_mv_d;
		end
	end

	// Pin is asynchronous; two flops before any edge logic
	always_comb begin
		pin_meta_d = enable_pin;
		pin_sync_d = pin_meta_q;
		pin_prev_d = pin_sync_q;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			pin_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= pin_meta_d;
			pin_sync_q <= pin_sync_d;
			pin_prev_q <= pin_prev_d;
		end
	end

	assign pin_rise = pin_sync_q && !pin_prev_q;
	assign pin_fall = !pin_sync_q && pin_prev_q;

	linear_sequencer #(.STEP_CYC(STEP_CYC)) u_seq_a (
		.clk              (clk),
		.sys_rst          (sys_rst),
		.enable_bit       (ctrl_a_q[enable_bit_pos]),
		.pin_gating       (ctrl_a_q[pin_gating_pos]),
		.discharge_enable (ctrl_a_q[discharge_en_pos]),
		.startup_delay    (dly_a_q[3:0]),
		.shutdown_delay   (dly_a_q[7:4]),
		.pin_level        (pin_sync_q),
		.pin_rise         (pin_rise),
		.pin_fall         (pin_fall),
		.reg_on           (on_a),
		.discharge_on     (dis_a)
	);

	linear_sequencer #(.STEP_CYC(STEP_CYC)) u_seq_b (
		.clk              (clk),
		.sys_rst          (sys_rst),
		.enable_bit       (ctrl_b_q[enable_bit_pos]),
		.pin_gating       (ctrl_b_q[pin_gating_pos]),
		.discharge_enable (ctrl_b_q[discharge_en_pos]),
		.startup_delay    (dly_b_q[3:0]),
		.shutdown_delay   (dly_b_q[7:4]),
		.pin_level        (pin_sync_q),
		.pin_rise         (pin_rise),
		.pin_fall         (pin_fall),
		.reg_on           (on_b),
		.discharge_on     (dis_b)
	);

	assign reg_rdata              = rdata_q;
	assign converter_b_code       = conv_q;
	assign converter_b_target_mv  = conv_mv_q;
	assign converter_b_code_valid = conv_ok_q;
	assign linear_a_status        = '{enabled: on_a, discharge: dis_a, target_mv: lin_a_mv_q};
	assign linear_b_status        = '{enabled: on_b, discharge: dis_b, target_mv: lin_b_mv_q};
endmodule

// *** tb/regulator_regs_check_sva.sv ***
// Port assertions for the regulator register bank
`timescale 1ns/1ps
module regulator_regs_check
	import regulator_regs_pkg::*;
#(
	parameter int STEP_CYC = 4
) (
	// Clock and reset
	input wire logic           clk,
	input wire logic           sys_rst,
	// Register port
	input wire logic [7:0]     reg_addr,
	input wire logic [7:0]     reg_wdata,
	input wire logic           reg_wr,
	input wire logic           reg_rd,
	input wire logic [7:0]     reg_rdata,
	// Pin and targets
	input wire logic           enable_pin,
	input wire logic [7:0]     converter_b_code,
	input wire logic [15:0]    converter_b_target_mv,
	input wire logic           converter_b_code_valid,
	input wire linear_status_t linear_a_status,
	input wire linear_status_t linear_b_status
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence wr_at(logic [7:0] a);
		reg_wr && reg_addr == a;
	endsequence
	// Target lags the code one cycle, so compare against the past code
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_conv_read: assert property (reg_rd && reg_addr == 8'h07 |=> reg_rdata == $past(converter_b_code))
		else $error("converter read wrong");
	a_conv_write: assert property (wr_at(8'h07) |=> converter_b_code == $past(reg_wdata))
		else $error("converter write lost");
	a_fine_step: assert property (converter_b_code inside {[8'h14:8'h17]}
		|=> converter_b_target_mv == 16'h02BC + 16'h000A * ($past(converter_b_code) - 16'h0014))
		else $error("fine range target wrong");
	a_mid_step: assert property (converter_b_code inside {[8'h18:8'h9D]}
		|=> converter_b_target_mv == 16'h02DF + 16'h0005 * ($past(converter_b_code) - 16'h0018))
		else $error("mid range target wrong");
	a_coarse_step: assert property (converter_b_code >= 8'h9E
		|=> converter_b_target_mv == 16'h058C + 16'h0014 * ($past(converter_b_code) - 16'h009E))
		else $error("coarse range target wrong");
	a_lin_target: assert property (wr_at(8'h0A) ##0 reg_wdata[4:0] <= 5'h19
		|=> ##1 linear_a_status.target_mv == 16'h0320 + 16'h0064 * ($past(reg_wdata, 2) & 8'h1F))
		else $error("linear a target wrong");
	a_a_off: assert property (wr_at(8'h08) ##0 !reg_wdata[0] |=> ##1 !linear_a_status.enabled)
		else $error("linear a stays on");
	a_b_off: assert property (wr_at(8'h09) ##0 !reg_wdata[0] |=> ##1 !linear_b_status.enabled)
		else $error("linear b stays on");
	a_dis_idle: assert property (linear_a_status.discharge |-> !linear_a_status.enabled)
		else $error("discharge while on");
endmodule

bind regulator_enable_voltage_regs regulator_regs_check #(.STEP_CYC(STEP_CYC)) u_chk (
	.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enable_pin(enable_pin),
	.converter_b_code(converter_b_code), .converter_b_target_mv(converter_b_target_mv),
	.converter_b_code_valid(converter_b_code_valid), .linear_a_status(linear_a_status),
	.linear_b_status(linear_b_status));

// *** tb/regulator_enable_voltage_regs_test.sv ***
// Self-checking bench for the regulator register bank
`timescale 1ns/1ps
module regulator_enable_voltage_regs_test
	import regulator_regs_pkg::*;
	;
	// Short delay step keeps pin sequencing runs brief
	localparam int STEP = 4;
	logic           clk       = 1'b0;
	logic           sys_rst   = 1'b1;
	logic [7:0]     reg_addr  = 8'h00;
	logic [7:0]     reg_wdata = 8'h00;
	logic           reg_wr    = 1'b0;
	logic           reg_rd    = 1'b0;
	logic           enable_pin = 1'b0;
	logic [7:0]     reg_rdata;
	logic [7:0]     converter_b_code;
	logic [15:0]    converter_b_target_mv;
	logic           converter_b_code_valid;
	linear_status_t linear_a_status;
	linear_status_t linear_b_status;
	int             error_cnt = 0;
	int             cmp_count = 0;
	logic [7:0]     ra[6] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h20};
	logic [7:0]     rv[6] = '{8'h93, 8'h07, 8'h07, 8'h0A, 8'h0A, 8'h00};
	logic [7:0]     cc[6] = '{8'h14, 8'h17, 8'h18, 8'h9D, 8'h9E, 8'hFF};
	logic [15:0]    cm[6] = '{16'h02BC, 16'h02DA, 16'h02DF, 16'h0578, 16'h058C, 16'h0D20};

	always #50 clk = ~clk;

	regulator_enable_voltage_regs #(.STEP_CYC(STEP)) dut (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enable_pin(enable_pin),
		.converter_b_code(converter_b_code), .converter_b_target_mv(converter_b_target_mv),
		.converter_b_code_valid(converter_b_code_valid), .linear_a_status(linear_a_status),
		.linear_b_status(linear_b_status));

	task automatic test_done();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk({8'h00, reg_rdata}, {8'h00, exp});
	endtask

	task automatic wait_on(input logic b, input logic lvl);
		int   n;
		logic got;
		for (n = 0; n < 60; n++) begin
			@(posedge clk);
			#1;
			got = b ? linear_b_status.enabled : linear_a_status.enabled;
			if (got === lvl) break;
		end
		cmp_count++;
		if (n == 60) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, lvl);
			test_done();
		end
	endtask

	task automatic settle();
		@(posedge clk);
		#1;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		wr(8'h20, 8'hFF);
		for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
		chk(converter_b_target_mv, 16'h0546);
		chk(linear_b_status.target_mv, 16'h0708);
		chk({15'h0000, linear_a_status.enabled}, 16'h0000);
		chk({15'h0000, linear_a_status.discharge}, 16'h0001);
		for (int i = 0; i < 6; i++) begin
			wr(8'h07, cc[i]);
			rd(8'h07, cc[i]);
			chk({8'h00, converter_b_code}, {8'h00, cc[i]});
			chk(converter_b_target_mv, cm[i]);
			chk({15'h0000, converter_b_code_valid}, 16'h0001);
		end
		wr(8'h0A, 8'hF9);
		rd(8'h0A, 8'h19);
		chk(linear_a_status.target_mv, 16'h0CE4);
		wr(8'h0B, 8'h00);
		rd(8'h0B, 8'h00);
		chk(linear_b_status.target_mv, 16'h0320);
		wr(8'h08, 8'hF9);
		rd(8'h08, 8'h01);
		wait_on(1'b0, 1'b1);
		wr(8'h08, 8'h03);
		wait_on(1'b0, 1'b0);
		settle();
		chk({15'h0000, linear_a_status.discharge}, 16'h0000);
		wr(8'h08, 8'h07);
		settle();
		chk({15'h0000, linear_a_status.discharge}, 16'h0001);
		@(posedge clk);
		enable_pin <= 1'b1;
		repeat (3) settle();
		chk({15'h0000, linear_a_status.enabled}, 16'h0000);
		wait_on(1'b0, 1'b1);
		wait_on(1'b1, 1'b1);
		wr(8'h08, 8'h06);
		settle();
		chk({15'h0000, linear_a_status.enabled}, 16'h0000);
		wr(8'h08, 8'h07);
		wait_on(1'b0, 1'b1);
		@(posedge clk);
		enable_pin <= 1'b0;
		repeat (8) settle();
		chk({15'h0000, linear_a_status.enabled}, 16'h0001);
		chk({15'h0000, linear_b_status.enabled}, 16'h0001);
		wait_on(1'b0, 1'b0);
		wait_on(1'b1, 1'b0);
		wr(8'h09, 8'h01);
		wait_on(1'b1, 1'b1);
		wr(8'h09, 8'h00);
		settle();
		chk({15'h0000, linear_b_status.enabled}, 16'h0000);
		settle();
		chk({15'h0000, linear_b_status.discharge}, 16'h0000);
		wr(8'h09, 8'h04);
		repeat (2) settle();
		chk({15'h0000, linear_b_status.discharge}, 16'h0001);
		test_done();
	end
endmodule
